// ---- src/spm_pin_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux
    import spm_pkg::*;
#(
    parameter int NPIN = 8,
    parameter logic [NPIN-1:0] KEYPAD_MASK = 8'h0F
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [NPIN-1:0] alt1_en,
    input wire logic [NPIN-1:0] alt1_oe,
    input wire logic [NPIN-1:0] alt1_out,
    input wire logic [NPIN-1:0] alt2_en,
    input wire logic [NPIN-1:0] alt2_oe,
    input wire logic [NPIN-1:0] alt2_out,
    input wire logic [NPIN-1:0] keypad_rise_sel,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic [NPIN-1:0] pin_pull_en,
    output logic [NPIN-1:0] pin_pull_dn,
    output logic [NPIN-1:0] periph_in,
    input wire logic irq_pin,
    output logic irq_request,
    output logic branch_if_pin_high,
    output logic branch_if_pin_low,
    output logic irq_pull_en,
    output logic irq_pull_dn,
    input wire logic debug_mode_select_pin,
    output logic run_mode,
    output logic debug_mode,
    output logic vec_req,
    output logic [15:0] vec_addr,
    input wire logic vec_ack,
    input wire logic [7:0] vec_rdata,
    output logic cpu_start,
    output logic [15:0] cpu_start_pc
);
    logic [NPIN-1:0] pin_sync;
    logic irq_sync;
    logic mode_sync;
    logic [NPIN-1:0] data_reg;
    logic [NPIN-1:0] dir_reg;
    logic [NPIN-1:0] pull_reg;
    logic [2:0] irq_ctrl_reg;
    logic irq_prev_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [1:0] settle_cnt_reg;
    logic [7:0] vec_hi_reg;
    spm_boot_e boot_reg;
    logic [NPIN-1:0] own1;
    logic [NPIN-1:0] own2;
    logic [NPIN-1:0] oe_next;
    logic [NPIN-1:0] out_next;
    logic [NPIN-1:0] port_read;
    logic addr_phase;
    logic irq_en;
    logic irq_rise;
    logic irq_edge;

    // Mode and interrupt pins idle high, data pins low; the mode strap is sampled only once real pin data has replaced these values
    spm_sync2 #(
        .W(NPIN + 2),
        .RST_VAL({2'b11, {NPIN{1'b0}}})
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({debug_mode_select_pin, irq_pin, pin_in}),
        .q({mode_sync, irq_sync, pin_sync})
    );

    // Word-aligned field helper
    function automatic logic [31:0] spm_zext(input logic [NPIN-1:0] v);
        spm_zext = 32'h0000_0000;
        spm_zext[NPIN-1:0] = v;
    endfunction

    // Ownership: second alternate beats first, first beats port
    assign own2 = alt2_en;
    assign own1 = alt1_en & ~alt2_en;

    // Direction and value from the winning owner
    always_comb
    begin
        for (int i = 0; i < NPIN; i++)
        begin
            if (own2[i])
            begin
                oe_next[i] = alt2_oe[i];
                out_next[i] = alt2_out[i];
            end
            else if (own1[i])
            begin
                oe_next[i] = alt1_oe[i];
                out_next[i] = alt1_out[i];
            end
            else
            begin
                oe_next[i] = dir_reg[i];
                out_next[i] = data_reg[i];
            end
        end
    end

    // Read-back still follows the direction bit, owner or not
    assign port_read = (dir_reg & data_reg) | (~dir_reg & pin_sync);

    // Pad controls, registered; reset leaves unpulled inputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_oe <= '0;
            pin_out <= '0;
            pin_pull_en <= '0;
            pin_pull_dn <= '0;
            periph_in <= '0;
        end
        else
        begin
            pin_oe <= oe_next;
            pin_out <= out_next;
            pin_pull_en <= pull_reg & ~oe_next;
            pin_pull_dn <= KEYPAD_MASK & own1 & keypad_rise_sel;
            periph_in <= pin_sync;
        end
    end

    assign irq_en = irq_ctrl_reg[SPM_IRQ_EN_BIT];
    assign irq_rise = irq_ctrl_reg[SPM_IRQ_RISE_BIT];
    assign irq_edge = irq_rise ? (irq_sync & ~irq_prev_reg) : (~irq_sync & irq_prev_reg);

    // Interrupt pin: one source for request and branch test
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_prev_reg <= 1'b1;
            irq_request <= 1'b0;
            branch_if_pin_high <= 1'b0;
            branch_if_pin_low <= 1'b0;
            irq_pull_en <= 1'b0;
            irq_pull_dn <= 1'b0;
        end
        else
        begin
            irq_prev_reg <= irq_sync;
            irq_request <= irq_en & irq_edge;
            branch_if_pin_high <= irq_en & irq_sync;
            branch_if_pin_low <= irq_en & ~irq_sync;
            irq_pull_en <= irq_en & irq_ctrl_reg[SPM_IRQ_PULL_BIT] & ~irq_rise;
            irq_pull_dn <= irq_en & irq_ctrl_reg[SPM_IRQ_PULL_BIT] & irq_rise;
        end
    end

    // Boot sequencer: strap sampled once the synchroniser holds real data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            boot_reg <= SPM_ST_SETTLE;
            settle_cnt_reg <= 2'h0;
            vec_hi_reg <= 8'h00;
            vec_req <= 1'b0;
            vec_addr <= 16'h0000;
            cpu_start <= 1'b0;
            cpu_start_pc <= 16'h0000;
            run_mode <= 1'b0;
            debug_mode <= 1'b0;
        end
        else
        begin
            cpu_start <= 1'b0;
            case (boot_reg)
                SPM_ST_SETTLE:
                begin
                    if (settle_cnt_reg != SPM_SAMPLE_WAIT)
                    begin
                        settle_cnt_reg <= settle_cnt_reg + 2'h1;
                    end
                    else if (mode_sync)
                    begin
                        boot_reg <= SPM_ST_FETCH_HI;
                        run_mode <= 1'b1;
                        vec_req <= 1'b1;
                        vec_addr <= SPM_VEC_HI_ADDR;
                    end
                    else
                    begin
                        boot_reg <= SPM_ST_DEBUG;
                        debug_mode <= 1'b1;
                    end
                end
                SPM_ST_DEBUG:
                begin
                    boot_reg <= SPM_ST_DEBUG;
                end
                SPM_ST_FETCH_HI:
                begin
                    if (vec_ack)
                    begin
                        vec_hi_reg <= vec_rdata;
                        vec_addr <= SPM_VEC_LO_ADDR;
                        boot_reg <= SPM_ST_FETCH_LO;
                    end
                end
                SPM_ST_FETCH_LO:
                begin
                    if (vec_ack)
                    begin
                        vec_req <= 1'b0;
                        cpu_start <= 1'b1;
                        cpu_start_pc <= {vec_hi_reg, vec_rdata};
                        boot_reg <= SPM_ST_RUN;
                    end
                end
                SPM_ST_RUN:
                begin
                    boot_reg <= SPM_ST_RUN;
                end
                default:
                begin
                    boot_reg <= SPM_ST_SETTLE;
                end
            endcase
        end
    end

    // AHB-Lite slave, zero wait states
    assign addr_phase = hsel & hready & (htrans == SPM_HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_reg <= addr_phase & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Control writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            data_reg <= SPM_RST_DATA[NPIN-1:0];
            dir_reg <= SPM_RST_DIR[NPIN-1:0];
            pull_reg <= SPM_RST_PULL[NPIN-1:0];
            irq_ctrl_reg <= SPM_RST_IRQ;
        end
        else if (wr_pend_reg)
        begin
            case (wr_addr_reg)
                SPM_OFS_DATA: data_reg <= hwdata[NPIN-1:0];
                SPM_OFS_DIR: dir_reg <= hwdata[NPIN-1:0];
                SPM_OFS_PULL: pull_reg <= hwdata[NPIN-1:0];
                SPM_OFS_IRQ: irq_ctrl_reg <= hwdata[2:0];
                default: irq_ctrl_reg <= irq_ctrl_reg;
            endcase
        end
    end

    // Read data captured in the address phase, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= SPM_HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= SPM_HRESP_OKAY;
            if (addr_phase & ~hwrite)
            begin
                case (haddr[7:0])
                    SPM_OFS_DATA: hrdata <= spm_zext(port_read);
                    SPM_OFS_DIR: hrdata <= spm_zext(dir_reg);
                    SPM_OFS_PULL: hrdata <= spm_zext(pull_reg);
                    SPM_OFS_IRQ: hrdata <= {29'h0, irq_ctrl_reg};
                    SPM_OFS_STATUS: hrdata <= {29'h0, irq_en & irq_sync, debug_mode, run_mode};
                    SPM_OFS_OWN1: hrdata <= spm_zext(own1);
                    SPM_OFS_OWN2: hrdata <= spm_zext(own2);
                    SPM_OFS_START: hrdata <= {16'h0000, cpu_start_pc};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_owner2_oe;
        alt2_en[0] |=> pin_oe[0] == $past(alt2_oe[0]);
    endproperty
    a_owner2_oe: assert property (p_owner2_oe) else $error("second owner lost pin");

    property p_owner1_oe;
        (alt1_en[1] && !alt2_en[1]) |=> pin_oe[1] == $past(alt1_oe[1]);
    endproperty
    a_owner1_oe: assert property (p_owner1_oe) else $error("first owner lost pin");

    property p_port_owns;
        (alt1_en[2] == 1'b0 && alt2_en[2] == 1'b0) |=> pin_oe[2] == $past(dir_reg[2]) && pin_out[2] == $past(data_reg[2]);
    endproperty
    a_port_owns: assert property (p_port_owns) else $error("port not driving unowned pin");

    property p_pull_input;
        (!pin_oe[3]) |-> pin_pull_en[3] == $past(pull_reg[3]);
    endproperty
    a_pull_input: assert property (p_pull_input) else $error("pull not applied on input");

    property p_kbd_down;
        (alt1_en[0] && !alt2_en[0] && keypad_rise_sel[0] && KEYPAD_MASK[0]) |=> pin_pull_dn[0];
    endproperty
    a_kbd_down: assert property (p_kbd_down) else $error("keypad pulldown missing");

    property p_irq_quiet;
        !irq_en ##1 !irq_en |-> !irq_request && !branch_if_pin_high && !branch_if_pin_low && !irq_pull_en;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("disabled interrupt pin active");

    property p_irq_rise_pull;
        (irq_en && irq_rise && irq_ctrl_reg[SPM_IRQ_PULL_BIT]) |=> irq_pull_dn && !irq_pull_en;
    endproperty
    a_irq_rise_pull: assert property (p_irq_rise_pull) else $error("rising irq not pulled down");

    property p_irq_branch;
        irq_en ##1 irq_en |-> branch_if_pin_high == $past(irq_sync) && branch_if_pin_low != branch_if_pin_high;
    endproperty
    a_irq_branch: assert property (p_irq_branch) else $error("branch level mismatch");

    property p_mode_excl;
        $rose(run_mode) |=> (!debug_mode && $stable(run_mode)) [*2];
    endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("mode not stable");

    property p_vec_first;
        $rose(vec_req) |-> vec_addr == SPM_VEC_HI_ADDR && run_mode;
    endproperty
    a_vec_first: assert property (p_vec_first) else $error("vector fetch not at top");

    property p_reset_read;
        (addr_phase && !hwrite && haddr[7:0] == SPM_OFS_DATA && dir_reg == '0) |=> hrdata[NPIN-1:0] == $past(pin_sync);
    endproperty
    a_reset_read: assert property (p_reset_read) else $error("input read-back wrong");
endmodule // spm_pin_mux
`default_nettype wire

// ---- src/spm_pkg.sv ----
// Contract
// - Interrupt pin feeds request and branch test
// - Disabled interrupt pin has no effect
// - Rising-edge interrupt selects pulldown, not pullup
// - After reset pins are unpulled inputs
// - Direction bit selects port data read-back
// - Owning peripheral drives output enable
// - Pull enable acts whenever pin is input
// - Keypad rising sensitivity turns pull into pulldown
// - Priority: port, first alternate, second alternate
// - Only highest enabled owner controls pin
// - Mode pin high at reset release: run
// - Run mode fetches start vector from top
// - Mode pin low at reset release: debug
package spm_pkg;
    // Register byte offsets
    localparam logic [7:0] SPM_OFS_DATA = 8'h00;
    localparam logic [7:0] SPM_OFS_DIR = 8'h04;
    localparam logic [7:0] SPM_OFS_PULL = 8'h08;
    localparam logic [7:0] SPM_OFS_IRQ = 8'h0C;
    localparam logic [7:0] SPM_OFS_STATUS = 8'h10;
    localparam logic [7:0] SPM_OFS_OWN1 = 8'h14;
    localparam logic [7:0] SPM_OFS_OWN2 = 8'h18;
    localparam logic [7:0] SPM_OFS_START = 8'h1C;
    // Interrupt control field positions
    localparam int SPM_IRQ_EN_BIT = 0;
    localparam int SPM_IRQ_RISE_BIT = 1;
    localparam int SPM_IRQ_PULL_BIT = 2;
    // Status field positions
    localparam int SPM_ST_RUN_BIT = 0;
    localparam int SPM_ST_DBG_BIT = 1;
    localparam int SPM_ST_IRQ_LVL_BIT = 2;
    // Reset values
    localparam logic [31:0] SPM_RST_DATA = 32'h0000_0000;
    localparam logic [31:0] SPM_RST_DIR = 32'h0000_0000;
    localparam logic [31:0] SPM_RST_PULL = 32'h0000_0000;
    localparam logic [2:0] SPM_RST_IRQ = 3'h0;
    // Reset vector bytes, high byte first
    localparam logic [15:0] SPM_VEC_HI_ADDR = 16'hFFFE;
    localparam logic [15:0] SPM_VEC_LO_ADDR = 16'hFFFF;
    // Edges to wait for the mode pin synchroniser to fill
    localparam logic [1:0] SPM_SAMPLE_WAIT = 2'h2;
    // AHB encodings
    localparam logic [1:0] SPM_HTRANS_NONSEQ = 2'h2;
    localparam logic SPM_HRESP_OKAY = 1'b0;
    // Boot and mode sequencer states
    typedef enum logic [4:0] {
        SPM_ST_SETTLE = 5'b00001,
        SPM_ST_DEBUG = 5'b00010,
        SPM_ST_FETCH_HI = 5'b00100,
        SPM_ST_FETCH_LO = 5'b01000,
        SPM_ST_RUN = 5'b10000
    } spm_boot_e;
endpackage

// ---- src/spm_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module spm_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // spm_sync2
`default_nettype wire

// ---- test/spm_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side of the block: the pads with an outside driver, and the boot vector memory
module spm_far_model
    import spm_pkg::*;
#(
    parameter int NPIN = 8,
    parameter logic [7:0] VEC_HI = 8'h3C,
    parameter logic [7:0] VEC_LO = 8'h5A
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [NPIN-1:0] ext_lvl,
    output logic [NPIN-1:0] pin_in,
    input wire logic vec_req,
    input wire logic [15:0] vec_addr,
    input wire logic [3:0] ack_delay,
    output logic vec_ack,
    output logic [7:0] vec_rdata
);
    logic [3:0] wait_cnt;

    // Own drive wins at the pad, otherwise the outside device sets the level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

    // Vector memory; data is scrambled once the ack is gone so nothing stale passes
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vec_ack <= 1'b0;
            wait_cnt <= 4'h0;
            vec_rdata <= 8'hA5;
        end
        else if (vec_ack)
        begin
            vec_ack <= 1'b0;
            wait_cnt <= 4'h0;
            vec_rdata <= ~vec_rdata;
        end
        else if (vec_req)
        begin
            if (wait_cnt == ack_delay)
            begin
                vec_ack <= 1'b1;
                vec_rdata <= (vec_addr == SPM_VEC_HI_ADDR) ? VEC_HI : VEC_LO;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule // spm_far_model
`default_nettype wire

// ---- test/tb_shared_pin_priority_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_shared_pin_priority_mux import spm_pkg::*;;
    localparam logic [7:0] KP_MASK = 8'h0F;
    localparam logic [7:0] VEC_HI = 8'hC3;
    localparam logic [7:0] VEC_LO = 8'h18;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_v;
    logic [1:0] htrans = 2'h0;
    logic [7:0] alt1_en = 8'h0, alt1_oe = 8'h0, alt1_out = 8'h0, alt2_en = 8'h0, alt2_oe = 8'h0;
    logic [7:0] alt2_out = 8'h0, keypad_rise_sel = 8'h0, ext_lvl = 8'h0, pin_in, pin_out, pin_oe;
    logic [7:0] pin_pull_en, pin_pull_dn, periph_in, dir_v, dat_v, pul_v, oe_x, out_x, pl_x, dn_x, lv_x;
    logic irq_pin = 1'b0, debug_mode_select_pin = 1'b1, irq_request, branch_if_pin_high;
    logic branch_if_pin_low, irq_pull_en, irq_pull_dn, run_mode, debug_mode, vec_req, vec_ack, cpu_start;
    logic [15:0] vec_addr, cpu_start_pc, last_pc;
    logic [7:0] vec_rdata;
    logic [3:0] ack_delay = 4'h0;
    int fail_count = 0, total_checks = 0, cycles = 0, irq_cnt = 0, start_cnt = 0;

    spm_pin_mux #(.NPIN(8), .KEYPAD_MASK(KP_MASK)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .alt1_en(alt1_en), .alt1_oe(alt1_oe),
        .alt1_out(alt1_out), .alt2_en(alt2_en), .alt2_oe(alt2_oe), .alt2_out(alt2_out),
        .keypad_rise_sel(keypad_rise_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_en(pin_pull_en), .pin_pull_dn(pin_pull_dn), .periph_in(periph_in), .irq_pin(irq_pin),
        .irq_request(irq_request), .branch_if_pin_high(branch_if_pin_high), .branch_if_pin_low(branch_if_pin_low),
        .irq_pull_en(irq_pull_en), .irq_pull_dn(irq_pull_dn), .debug_mode_select_pin(debug_mode_select_pin),
        .run_mode(run_mode), .debug_mode(debug_mode), .vec_req(vec_req), .vec_addr(vec_addr),
        .vec_ack(vec_ack), .vec_rdata(vec_rdata), .cpu_start(cpu_start), .cpu_start_pc(cpu_start_pc));

    spm_far_model #(.NPIN(8), .VEC_HI(VEC_HI), .VEC_LO(VEC_LO)) i_far (.hclk(hclk), .hresetn(hresetn),
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in), .vec_req(vec_req),
        .vec_addr(vec_addr), .ack_delay(ack_delay), .vec_ack(vec_ack), .vec_rdata(vec_rdata));

    // 200 MHz bus clock
    always #2.5 hclk = ~hclk;

    // Hang guard and event counters for one-cycle pulses
    always @(posedge hclk)
    begin
        cycles++;
        if (irq_request === 1'b1)
            irq_cnt++;
        if (cpu_start === 1'b1)
        begin
            start_cnt++;
            last_pc = cpu_start_pc;
        end
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // One single-word transfer; waits stay open-ended, only the hang guard ends them
    task automatic ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, adr};
        htrans <= SPM_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic do_reset(input logic strap, input logic [3:0] dly);
        @(posedge hclk);
        hresetn <= 1'b0;
        debug_mode_select_pin <= strap;
        ack_delay <= dly;
        alt1_en <= 8'h00;
        alt2_en <= 8'h00;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        start_cnt = 0;
        chk(32'(pin_oe), 0, "pins not inputs");
        chk(32'(pin_pull_en), 0, "pull on at reset");
    endtask

    initial
    begin
        void'($urandom(32'h2df8));
        // Strap low, then prompt and slow vector memory in run mode
        for (int m = 0; m < 3; m++)
        begin
            do_reset(m != 0, (m == 1) ? 4'h0 : 4'h5);
            gap(40);
            if (m == 0)
            begin
                chk(32'(debug_mode), 1, "debug entry");
                chk(32'(run_mode), 0, "run in debug");
                chk(start_cnt, 0, "fetch in debug");
            end
            else
            begin
                chk(32'(run_mode), 1, "run entry");
                chk(start_cnt, 1, "start pulses");
                chk(32'(last_pc), {16'h0, VEC_HI, VEC_LO}, "start pc");
                ahb(1'b0, SPM_OFS_START, 32'h0, rd_v);
                chk(rd_v, {16'h0, VEC_HI, VEC_LO}, "start reg");
                ahb(1'b0, SPM_OFS_STATUS, 32'h0, rd_v);
                chk(32'(rd_v[1:0]), 1, "mode status");
            end
        end
        ahb(1'b0, 8'h40, 32'h0, rd_v);
        chk(rd_v, 0, "unmapped read");
        chk(32'(hresp), 32'(SPM_HRESP_OKAY), "bus response");
        // Ownership sweep: both owners on, none, then random mixes
        for (int i = 0; i < 24; i++)
        begin
            // All-input corner so the plain pin read-back is exercised
            dir_v = (i == 1) ? 8'h00 : 8'($urandom);
            dat_v = 8'($urandom);
            pul_v = 8'($urandom);
            ahb(1'b1, SPM_OFS_DIR, {24'h0, dir_v}, rd_v);
            ahb(1'b1, SPM_OFS_DATA, {24'h0, dat_v}, rd_v);
            ahb(1'b1, SPM_OFS_PULL, {24'h0, pul_v}, rd_v);
            @(posedge hclk);
            alt1_en <= 8'h00;
            alt2_en <= 8'h00;
            @(posedge hclk);
            alt1_en <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            alt2_en <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            alt1_oe <= 8'($urandom);
            alt1_out <= 8'($urandom);
            alt2_oe <= 8'($urandom);
            alt2_out <= 8'($urandom);
            keypad_rise_sel <= 8'($urandom);
            ext_lvl <= 8'($urandom);
            gap(5);
            oe_x = (alt2_en & alt2_oe) | (~alt2_en & alt1_en & alt1_oe) | (~alt2_en & ~alt1_en & dir_v);
            out_x = (alt2_en & alt2_out) | (~alt2_en & alt1_en & alt1_out) | (~alt2_en & ~alt1_en & dat_v);
            pl_x = pul_v & ~oe_x;
            dn_x = KP_MASK & alt1_en & ~alt2_en & keypad_rise_sel;
            lv_x = (oe_x & out_x) | (~oe_x & ext_lvl);
            chk(32'(pin_oe), 32'(oe_x), "pad enable");
            chk(32'(pin_out & oe_x), 32'(out_x & oe_x), "pad value");
            chk(32'(pin_pull_en), 32'(pl_x), "pull enable");
            chk(32'((pin_pull_dn ^ dn_x) & pl_x), 0, "pull direction");
            chk(32'(periph_in), 32'(lv_x), "peripheral input");
            ahb(1'b0, SPM_OFS_DATA, 32'h0, rd_v);
            chk(rd_v, 32'((dat_v & dir_v) | (~dir_v & lv_x)), "read");
            ahb(1'b0, SPM_OFS_OWN1, 32'h0, rd_v);
            chk(rd_v, 32'(alt1_en & ~alt2_en), "first owner map");
            ahb(1'b0, SPM_OFS_OWN2, 32'h0, rd_v);
            chk(rd_v, 32'(alt2_en), "second owner map");
        end
        // Disabled interrupt pin: edges and level do nothing
        ahb(1'b1, SPM_OFS_IRQ, 32'h0, rd_v);
        irq_cnt = 0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge hclk);
            irq_pin <= ~irq_pin;
            gap(4);
        end
        chk(irq_cnt, 0, "disabled request");
        chk(32'({branch_if_pin_high, branch_if_pin_low, irq_pull_en, irq_pull_dn}), 0, "disabled pin");
        // Edge and pull chosen before the function is switched on
        ahb(1'b1, SPM_OFS_IRQ, 32'h6, rd_v);
        ahb(1'b1, SPM_OFS_IRQ, 32'h7, rd_v);
        gap(6);
        irq_cnt = 0;
        @(posedge hclk);
        irq_pin <= 1'b1;
        gap(6);
        chk(irq_cnt, 1, "rising request");
        chk(32'({branch_if_pin_high, branch_if_pin_low}), 2, "branch high");
        chk(32'(irq_pull_dn), 1, "rising pulldown");
        ahb(1'b1, SPM_OFS_IRQ, 32'h5, rd_v);
        gap(4);
        irq_cnt = 0;
        @(posedge hclk);
        irq_pin <= 1'b0;
        gap(6);
        chk(irq_cnt, 1, "falling request");
        chk(32'({branch_if_pin_high, branch_if_pin_low}), 1, "branch low");
        chk(32'({irq_pull_en, irq_pull_dn}), 2, "falling pullup");
        test_done();
    end
endmodule // tb_shared_pin_priority_mux
`default_nettype wire
